// File: bit_pick.sv
// Selects one bit of a byte by index
`timescale 1ns/1ps
module bit_pick (
	// Operand
	input wire logic [7:0] data,
	input wire logic [2:0] idx,
	// Result
	output logic bit_out
);
	logic [7:0] hit;

	// One-hot gate per bit
	for (genvar i = 0; i < 8; i++) begin : g_bit
		assign hit[i] = data[i] & (idx == 3'(i));
	end

	assign bit_out = |hit;
endmodule : bit_pick

// File: skip_branch_unit.sv
// Conditional skip and relative branch execution unit
`timescale 1ns/1ps
`include "skip_cfg.svh"
module skip_branch_unit
	import skip_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Request from decoder
	input wire logic req_valid,
	input wire skip_req_s req,
	// Result to program counter
	output logic busy_q,
	output logic done_q,
	output skip_res_s res_q
);
	unit_state_e state_q;
	unit_state_e state_d;
	logic [2:0] cnt_q;
	logic src_bit;
	logic [7:0] src_byte;
	logic cond;
	logic [2:0] cycles;
	logic [15:0] step;
	logic [15:0] k_ext;
	logic accept;
	logic is_io;
	logic is_br;
	logic want_set;
	logic one_cyc;
	logic last_cyc;
	logic [15:0] pc_sum;

	// Operand byte for the bit test
	always_comb begin
		src_byte = req.reg_val;
		if (is_io) begin
			src_byte = req.io_val;
		end else if (is_br) begin
			src_byte = req.core_status_register;
		end
	end

	bit_pick u_pick (
		.data(src_byte),
		.idx(req.bit_idx),
		.bit_out(src_bit)
	);

	assign k_ext = {{(16 - `OFS_W){req.offset_k[`OFS_W - 1]}}, req.offset_k};
	assign accept = req_valid && (state_q == ST_IDLE);

	// Single-cycle op and last cycle of a long one
	assign one_cyc = (cycles == 3'h1);
	assign last_cyc = (state_q == ST_RUN) && (cnt_q == 3'h0);

	// New PC wraps modulo the PC width
	assign pc_sum = 16'(req.pc + step);

	// Operand source and wanted bit level
	always_comb begin
		is_io = 1'b0;
		is_br = 1'b0;
		want_set = 1'b0;
		case (req.op)
			OP_SKIP_IF_REG_BIT_CLEAR: begin
				want_set = 1'b0;
			end
			OP_SKIP_IF_REG_BIT_SET: begin
				want_set = 1'b1;
			end
			OP_SKIP_IF_IO_BIT_CLEAR: begin
				is_io = 1'b1;
			end
			OP_SKIP_IF_IO_BIT_SET: begin
				is_io = 1'b1;
				want_set = 1'b1;
			end
			OP_BRANCH_IF_FLAG_SET: begin
				is_br = 1'b1;
				want_set = 1'b1;
			end
			OP_BRANCH_IF_FLAG_CLEAR: begin
				is_br = 1'b1;
			end
			default: begin
				want_set = 1'b0;
			end
		endcase
	end

	// Bit test against the wanted level
	always_comb begin
		cond = 1'b0;
		case (req.op)
			OP_SKIP_IF_REG_BIT_CLEAR, OP_SKIP_IF_REG_BIT_SET: begin
				cond = (src_bit == want_set);
			end
			OP_SKIP_IF_IO_BIT_CLEAR, OP_SKIP_IF_IO_BIT_SET: begin
				cond = (src_bit == want_set);
			end
			OP_BRANCH_IF_FLAG_SET, OP_BRANCH_IF_FLAG_CLEAR: begin
				cond = (src_bit == want_set);
			end
			default: begin
				cond = 1'b0;
			end
		endcase
	end

	// Cycle count of the operation
	always_comb begin
		cycles = `CYC_REG_FALSE;
		case (req.op)
			OP_SKIP_IF_REG_BIT_CLEAR, OP_SKIP_IF_REG_BIT_SET: begin
				if (cond) begin
					cycles = req.next_two_word ? `CYC_REG_SKIP2 : `CYC_REG_SKIP1;
				end
			end
			OP_SKIP_IF_IO_BIT_CLEAR, OP_SKIP_IF_IO_BIT_SET: begin
				cycles = `CYC_IO_FALSE;
				if (cond) begin
					cycles = req.next_two_word ? `CYC_IO_SKIP2 : `CYC_IO_SKIP1;
				end
			end
			OP_BRANCH_IF_FLAG_SET, OP_BRANCH_IF_FLAG_CLEAR: begin
				cycles = cond ? `CYC_BR_TAKEN : `CYC_BR_FALSE;
			end
			default: begin
				cycles = `CYC_REG_FALSE;
			end
		endcase
	end

	// Program counter step
	always_comb begin
		step = `PC_STEP_ONE;
		if (cond && is_br) begin
			step = 16'(k_ext + `PC_STEP_ONE);
		end else if (cond) begin
			step = req.next_two_word ? `PC_STEP_SKIP2 : `PC_STEP_SKIP1;
		end
	end

	// Next state of the sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (accept && !one_cyc) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (last_cyc) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Sequencer state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// Remaining cycles after the first
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 3'h0;
		end else if (ce) begin
			if (accept && !one_cyc) begin
				cnt_q <= 3'(cycles - 3'h2);
			end else if (state_q == ST_RUN && !last_cyc) begin
				cnt_q <= 3'(cnt_q - 3'h1);
			end
		end
	end

	// Busy while a multi-cycle operation runs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
		end else if (ce) begin
			busy_q <= (state_d == ST_RUN);
		end
	end

	// Completion pulse at the last cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= (accept && one_cyc) || last_cyc;
		end
	end

	// Result captured at acceptance
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			res_q <= '0;
		end else if (ce && accept) begin
			res_q.taken <= cond;
			res_q.pc_next <= pc_sum;
		end
	end
endmodule : skip_branch_unit

// File: skip_branch_unit_sva.sv
// Assertions for the skip and branch unit
`timescale 1ns/1ps
module skip_branch_unit_sva import skip_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Request
	input wire logic req_valid,
	input wire skip_req_s req,
	// Result
	input wire logic busy_q,
	input wire logic done_q,
	input wire skip_res_s res_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Accept and tested bits
	wire a = ce && req_valid && !busy_q;
	wire rb = req.reg_val[req.bit_idx];
	wire ib = req.io_val[req.bit_idx];
	wire sb = req.core_status_register[req.bit_idx];
	wire [15:0] sk = req.pc + (req.next_two_word ? 16'h0003 : 16'h0002);
	wire [15:0] bt = req.pc + {{9{req.offset_k[6]}}, req.offset_k} + 16'h0001;
	a_reg_clr:
	assert property (a && req.op == OP_SKIP_IF_REG_BIT_CLEAR && !rb |=> res_q.pc_next == $past(sk))
		else $error("reg clear step");
	a_reg_set:
	assert property (a && req.op == OP_SKIP_IF_REG_BIT_SET && rb && !req.next_two_word
		|=> busy_q ##1 done_q) else $error("reg set cycles");
	a_io_clr:
	assert property (a && req.op == OP_SKIP_IF_IO_BIT_CLEAR && !ib && req.next_two_word
		|=> busy_q[*3] ##1 done_q) else $error("io clear cycles");
	a_io_set:
	assert property (a && req.op == OP_SKIP_IF_IO_BIT_SET && ib |=> res_q.pc_next == $past(sk))
		else $error("io set step");
	a_br_set:
	assert property (a && req.op == OP_BRANCH_IF_FLAG_SET && sb |=> res_q.pc_next == $past(bt))
		else $error("branch set target");
	a_br_clr:
	assert property (a && req.op == OP_BRANCH_IF_FLAG_CLEAR && !sb |=> busy_q ##1 done_q)
		else $error("branch clear cycles");
	a_false_fast:
	assert property (a && req.op == OP_SKIP_IF_REG_BIT_SET && !rb |=> done_q && !res_q.taken)
		else $error("false not fast");
endmodule : skip_branch_unit_sva
bind skip_branch_unit skip_branch_unit_sva skip_branch_unit_sva_inst (.clk_sys, .rst_n, .ce,
	.req_valid, .req, .busy_q, .done_q, .res_q);

// File: skip_cfg.svh
// Constants for the conditional skip and branch unit
// Behaviour
// - A register-bit skip on a clear bit advances the PC by 2 or 3 in 1, 2 or 3 cycles, flags untouched.
// - A register-bit skip on a set bit advances the PC by 2 or 3 in 1, 2 or 3 cycles, flags untouched.
// - An I/O-bit skip on a clear bit advances the PC by 2 or 3 in 2, 3 or 4 cycles, flags untouched.
// - An I/O-bit skip on a set bit advances the PC by 2 or 3 in 2, 3 or 4 cycles, flags untouched.
// - A branch on a set status bit loads PC plus k plus 1 in 1 or 2 cycles, flags untouched.
// - A branch on a clear status bit loads PC plus k plus 1 in 1 or 2 cycles, flags untouched.
`ifndef SKIP_CFG_SVH
`define SKIP_CFG_SVH
`define PC_W 16
`define OFS_W 7
`define PC_STEP_ONE 16'h0001
`define PC_STEP_SKIP1 16'h0002
`define PC_STEP_SKIP2 16'h0003
`define CYC_REG_FALSE 3'h1
`define CYC_REG_SKIP1 3'h2
`define CYC_REG_SKIP2 3'h3
`define CYC_IO_FALSE 3'h2
`define CYC_IO_SKIP1 3'h3
`define CYC_IO_SKIP2 3'h4
`define CYC_BR_FALSE 3'h1
`define CYC_BR_TAKEN 3'h2
`endif

// File: skip_pkg.sv
// Types for the conditional skip and branch unit
package skip_pkg;
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_SKIP_IF_REG_BIT_CLEAR = 3'h1,
		OP_SKIP_IF_REG_BIT_SET = 3'h2,
		OP_SKIP_IF_IO_BIT_CLEAR = 3'h3,
		OP_SKIP_IF_IO_BIT_SET = 3'h4,
		OP_BRANCH_IF_FLAG_SET = 3'h5,
		OP_BRANCH_IF_FLAG_CLEAR = 3'h6
	} skip_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01
	} unit_state_e;

	typedef struct packed {
		skip_op_e op;
		logic [2:0] bit_idx;
		logic [7:0] reg_val;
		logic [7:0] io_val;
		logic [7:0] core_status_register;
		logic [6:0] offset_k;
		logic [15:0] pc;
		logic next_two_word;
	} skip_req_s;

	typedef struct packed {
		logic taken;
		logic [15:0] pc_next;
	} skip_res_s;
endpackage : skip_pkg

// File: tb_skip_branch_unit.sv
// Testbench for the skip and branch unit
`timescale 1ns/1ps
module tb_skip_branch_unit import skip_pkg::*; ;
	logic clk_sys = 0, rst_n = 0, req_valid = 0, ce = 1, busy_q, done_q;
	skip_req_s req = '0;
	skip_res_s res_q;
	int fail_count = 0, checked = 0, n;
	// Clock
	always #5 clk_sys = ~clk_sys;
	skip_branch_unit skip_branch_unit_inst (.clk_sys, .rst_n, .ce, .req_valid, .req,
		.busy_q, .done_q, .res_q);
	// Compare seen with expected
	task chk(input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// One request, then busy, pc, taken flag and cycle count
	task op(input skip_op_e o, logic [2:0] b, logic [7:0] v, logic t, logic [6:0] k,
		logic [15:0] p, e, int c, logic g);
		@(negedge clk_sys);
		req = '{o, b, v, v, v, k, p, t};
		req_valid = 1;
		@(negedge clk_sys);
		req_valid = 0;
		chk(16'(busy_q), 16'(c > 1));
		for (n = 1; n < 9 && done_q !== 1'b1; n++) @(negedge clk_sys);
		chk(res_q.pc_next, e);
		chk(16'(res_q.taken), 16'(g));
		chk(16'(n), 16'(c));
	endtask : op
	task t_reg;
		op(OP_SKIP_IF_REG_BIT_CLEAR, 3'h3, 8'hF7, 1, 0, 16'h0100, 16'h0103, 3, 1);
		op(OP_SKIP_IF_REG_BIT_SET, 3'h7, 8'h80, 0, 0, 16'h0200, 16'h0202, 2, 1);
		op(OP_SKIP_IF_REG_BIT_SET, 3'h0, 8'hFE, 1, 0, 16'hFFFF, 16'h0000, 1, 0);
		$display("register skips ended");
	endtask : t_reg
	task t_io;
		op(OP_SKIP_IF_IO_BIT_CLEAR, 3'h2, 8'hFB, 1, 0, 16'h0300, 16'h0303, 4, 1);
		op(OP_SKIP_IF_IO_BIT_SET, 3'h5, 8'h20, 0, 0, 16'h0400, 16'h0402, 3, 1);
		op(OP_SKIP_IF_IO_BIT_CLEAR, 3'h1, 8'h02, 0, 0, 16'h0500, 16'h0501, 2, 0);
		$display("io skips ended");
	endtask : t_io
	task t_br;
		op(OP_BRANCH_IF_FLAG_SET, 3'h1, 8'h02, 0, 7'h7F, 16'h0600, 16'h0600, 2, 1);
		op(OP_BRANCH_IF_FLAG_CLEAR, 3'h4, 8'hEF, 0, 7'h3F, 16'hFFF0, 16'h0030, 2, 1);
		op(OP_BRANCH_IF_FLAG_CLEAR, 3'h0, 8'h01, 0, 7'h05, 16'h0700, 16'h0701, 1, 0);
		$display("branches ended");
	endtask : t_br
	// Clock enable low freezes a running skip
	task t_ce;
		@(negedge clk_sys);
		req = '{OP_SKIP_IF_IO_BIT_SET, 3'h6, 8'h40, 8'h40, 8'h40, 7'h00, 16'h0800, 1'b1};
		req_valid = 1;
		@(negedge clk_sys);
		req_valid = 0;
		ce = 0;
		repeat (3) @(negedge clk_sys);
		chk(16'(busy_q), 16'h0001);
		chk(16'(done_q), 16'h0000);
		ce = 1;
		for (n = 1; n < 9 && done_q !== 1'b1; n++) @(negedge clk_sys);
		chk(res_q.pc_next, 16'h0803);
		chk(16'(n), 16'h0004);
		$display("clock enable test ended");
	endtask : t_ce
	task complete_run;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// Reset, then scenarios
	initial begin
		repeat (12) @(negedge clk_sys);
		rst_n = 1;
		t_reg;
		t_io;
		t_br;
		t_ce;
		complete_run;
	end
	// Watchdog
	initial begin
		#5000;
		fail_count++;
		complete_run;
	end
endmodule : tb_skip_branch_unit
